// ==== rtl/soic_pkg.sv ====
// Constants for the start-up options and identity check register group.
// Assumes a 32-bit register bus addressed by word index (byte address / 4).
package soic_pkg;
    // Word indices; the byte address is four times the index
    localparam logic [5:0] IDX_FRAME_DATA = 6'h02;
    localparam logic [5:0] IDX_STATUS = 6'h07;
    localparam logic [5:0] IDX_DAISY = 6'h08;
    localparam logic [5:0] IDX_OPTIONS = 6'h09;
    localparam logic [5:0] IDX_MFW = 6'h0A;
    localparam logic [5:0] IDX_IV = 6'h0B;
    localparam logic [5:0] IDX_IDENT = 6'h0C;
    localparam logic [5:0] IDX_USER = 6'h0D;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h11;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h12;
    localparam logic [5:0] IDX_CONTROL = 6'h13;
    // Start-up options word layout
    localparam int OPT_EXT_CLK_BIT = 26;
    localparam int OPT_DRIVE_DONE_BIT = 24;
    localparam int OPT_RATE_LSB = 17;
    localparam int RATE_W = 6;
    localparam int OPT_DONE_LSB = 12;
    localparam int OPT_MATCH_LSB = 9;
    localparam int OPT_LOCK_LSB = 6;
    localparam int OPT_GTS_LSB = 3;
    localparam int OPT_GWE_LSB = 0;
    localparam logic [31:0] OPT_RESET = 32'h0000_3FEC;
    localparam logic [31:0] OPT_MASK = 32'h057E_7FFF;
    localparam logic [2:0] CODE_NO_WAIT = 3'h7;
    localparam logic [2:0] CODE_TRACK_DONE = 3'h6;
    localparam logic [2:0] LAST_PHASE = 3'h7;
    // Status word layout
    localparam int STAT_PHASE_LSB = 18;
    localparam int STAT_IDERR_BIT = 15;
    localparam int STAT_DONE_PIN_BIT = 14;
    localparam int STAT_DONE_BIT = 13;
    localparam int STAT_GWE_BIT = 6;
    localparam int STAT_GTS_BIT = 5;
    localparam int STAT_EOS_BIT = 4;
    localparam int STAT_MATCH_BIT = 3;
    localparam int STAT_LOCK_BIT = 2;
    // Interrupt bits and control bits
    localparam int IRQ_IDERR = 0;
    localparam int IRQ_EOS = 1;
    localparam int IRQ_W = 2;
    localparam int CTRL_START_BIT = 0;
    // Internal rate divider step in clk_i cycles per rate code unit
    localparam int DIV_UNIT = 2;
endpackage : soic_pkg

// ==== rtl/soic_rate_div.sv ====
// Configuration clock tick source: internal divider or external clock.
// Assumes the external clock input is already synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module soic_rate_div #(
    parameter int UNIT = soic_pkg::DIV_UNIT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_sel_i,
    input wire logic ext_clk_i,
    input wire logic [5:0] rate_sel_i,
    output logic tick_o,
    output logic cfg_clock_o
);
    logic [15:0] cnt;
    logic [15:0] limit;
    logic ext_prev;
    logic next_tick;

    // Period grows with the rate code; code 0 is the fastest
    assign limit = 16'((32'(rate_sel_i) + 32'd1) * 32'(UNIT) - 32'd1);
    // External clock wins over the divider when selected
    assign next_tick = ext_sel_i ? (ext_clk_i && !ext_prev)
                                 : (cnt >= limit);

    // Divider counter and edge memory
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 16'h0000;
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_clk_i;
            cnt <= (ext_sel_i || cnt >= limit) ? 16'h0000 : cnt + 16'h0001;
        end
    end

    // Tick pulse and visible clock level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
            cfg_clock_o <= 1'b0;
        end else begin
            tick_o <= next_tick;
            if (next_tick) begin
                cfg_clock_o <= !cfg_clock_o;
            end
        end
    end

    a_ext_edge_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        ext_sel_i && ext_clk_i && !ext_prev |=> tick_o)
        else $error("external edge gave no tick");
endmodule : soic_rate_div
`default_nettype wire

// ==== rtl/soic_phase_seq.sv ====
// Start-up phase sequencer: eight phases, stalls and release points.
// Assumes one tick_i pulse per configuration clock from the divider.
`timescale 1ns/100ps
`default_nettype none
module soic_phase_seq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [2:0] done_code_i,
    input wire logic [2:0] match_code_i,
    input wire logic [2:0] lock_code_i,
    input wire logic [2:0] gts_code_i,
    input wire logic [2:0] gwe_code_i,
    input wire logic match_ok_i,
    input wire logic lock_ok_i,
    output logic [2:0] phase_o,
    output logic [2:0] phase_gray_o,
    output logic done_rel_o,
    output logic gts_rel_o,
    output logic gwe_rel_o,
    output logic end_o
);
    logic running;
    logic stall;
    logic next_done;

    // Hold the phase while calibration or lock is awaited there
    assign stall = (match_code_i != soic_pkg::CODE_NO_WAIT
                    && phase_o == match_code_i && !match_ok_i)
                || (lock_code_i != soic_pkg::CODE_NO_WAIT
                    && phase_o == lock_code_i && !lock_ok_i);

    // Phase counter; a new start restarts from phase 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            running <= 1'b0;
            phase_o <= 3'h0;
        end else if (start_i) begin
            running <= 1'b1;
            phase_o <= 3'h0;
        end else if (running && tick_i && !stall
                     && phase_o != soic_pkg::LAST_PHASE) begin
            phase_o <= phase_o + 3'h1;
        end
    end

    // Code 000 means phase 1, so release once the phase passes the code
    assign next_done = phase_o > done_code_i;

    // Release flags, all taken from the same phase snapshot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_rel_o <= 1'b0;
            gts_rel_o <= 1'b0;
            gwe_rel_o <= 1'b0;
        end else begin
            done_rel_o <= next_done;
            gts_rel_o <= (gts_code_i == soic_pkg::CODE_TRACK_DONE)
                         ? next_done : phase_o > gts_code_i;
            gwe_rel_o <= (gwe_code_i == soic_pkg::CODE_TRACK_DONE)
                         ? next_done : phase_o > gwe_code_i;
        end
    end

    assign phase_gray_o = phase_o ^ (phase_o >> 1);
    assign end_o = phase_o == soic_pkg::LAST_PHASE;

    a_match_stall: assert property (@(posedge clk_i) disable iff (rst_i)
        !start_i && match_code_i != 3'h7 && phase_o == match_code_i
        && !match_ok_i |=> phase_o == $past(phase_o))
        else $error("phase moved during impedance stall");
    a_lock_stall: assert property (@(posedge clk_i) disable iff (rst_i)
        !start_i && lock_code_i != 3'h7 && phase_o == lock_code_i
        && !lock_ok_i |=> phase_o == $past(phase_o))
        else $error("phase moved during lock stall");
    a_gray_last: assert property (@(posedge clk_i) disable iff (rst_i)
        phase_o == 3'h7 |-> phase_gray_o == 3'h4)
        else $error("last phase gray code wrong");
endmodule : soic_phase_seq
`default_nettype wire

// ==== rtl/soic_regs.sv ====
// Start-up options, daisy-chain output, cipher vector, user access value
// and identity check registers behind a classic Wishbone slave.
// Assumes a single clock domain and pins synchronous to clk_i.
// What this block does
// - Shift daisy-chain output register onto serial chain pin during daisy chaining.
// - Options bit 26 selects the external master configuration clock.
// - Options bit 24: 0 open-drain completion pin, 1 actively driven high.
// - Options bits 22:17 set the master configuration clock rate.
// - Options bits 14:12 pick completion release phase, codes 0-5 mean 1-6.
// - Options bits 11:9 pick impedance stall phase 0-6; 111 means none.
// - Options bits 8:6 pick clock-manager lock wait phase; 111 means none.
// - Options bits 5:3 pick tristate release phase; 110 follows completion.
// - Options bits 2:0 pick write-enable release phase; 110 follows completion.
// - Multi-frame write register feeds the compression path.
// - Cipher init vector register holds the decryption start vector.
// - Frame data is accepted only after a matching identity write.
// - Reading the identity register returns the built-in identity code.
// - User access register supplies the value seen by fabric logic.
// - Frame write without identity match sets status bit 15.
// - Status bits 20:18 report the phase in gray-style code.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module soic_regs #(
    // Arbitrary neutral identity value
    parameter logic [31:0] IDENTITY = 32'h0A5C_3001,
    parameter int DIV_STEP = soic_pkg::DIV_UNIT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic daisy_chain_active_i,
    output logic serial_chain_o,
    input wire logic external_master_cfg_clock_i,
    output logic cfg_clock_o,
    input wire logic impedance_calibration_match_i,
    input wire logic clock_manager_locked_i,
    input wire logic done_pin_i,
    output logic done_o,
    output logic done_oe_o,
    output logic global_tristate_o,
    output logic global_write_enable_o,
    output logic [31:0] frame_data_o,
    output logic frame_data_valid_o,
    output logic [31:0] multi_frame_write_o,
    output logic multi_frame_write_valid_o,
    output logic [31:0] cipher_init_vector_o,
    output logic [31:0] user_access_value_o,
    output logic irq_o
);
    logic [31:0] startup_options;
    logic [31:0] daisy_chain_out;
    logic [31:0] next_rdata;
    logic [31:0] wmask;
    logic [5:0] idx;
    logic req;
    logic wr_fire;
    logic id_ok;
    logic id_error;
    logic start_pulse;
    logic cfg_tick;
    logic [2:0] phase;
    logic [2:0] phase_gray;
    logic done_rel;
    logic gts_rel;
    logic gwe_rel;
    logic seq_end;
    logic end_prev;
    logic [soic_pkg::IRQ_W-1:0] irq_status;
    logic [soic_pkg::IRQ_W-1:0] irq_enable;
    logic [soic_pkg::IRQ_W-1:0] irq_event;
    logic [31:0] status_word;

    assign idx = adr_i[7:2];
    assign req = cyc_i && stb_i && !ack_o;
    // Writes land on the edge where the master sees ack
    assign wr_fire = cyc_i && stb_i && we_i && ack_o;

    // Byte-lane mask built from the select lines
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{sel_i[b]}};
        end
    end

    // One wait state per access, unmapped words answer too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Start-up options word; reserved bits never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            startup_options <= soic_pkg::OPT_RESET;
        end else if (wr_fire && idx == soic_pkg::IDX_OPTIONS) begin
            startup_options <= ((startup_options & ~wmask)
                                | (dat_i & wmask)) & soic_pkg::OPT_MASK;
        end
    end

    // Daisy-chain word shifts out MSB first on each config clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            daisy_chain_out <= 32'h0000_0000;
        end else if (wr_fire && idx == soic_pkg::IDX_DAISY) begin
            daisy_chain_out <= (daisy_chain_out & ~wmask) | (dat_i & wmask);
        end else if (daisy_chain_active_i && cfg_tick) begin
            daisy_chain_out <= {daisy_chain_out[30:0], 1'b0};
        end
    end

    // Pin stays low outside chaining so downstream devices see idle
    assign serial_chain_o = daisy_chain_active_i && daisy_chain_out[31];

    // Cipher vector and user access value hold until rewritten
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cipher_init_vector_o <= 32'h0000_0000;
            user_access_value_o <= 32'h0000_0000;
        end else if (wr_fire) begin
            if (idx == soic_pkg::IDX_IV) begin
                cipher_init_vector_o <= (cipher_init_vector_o & ~wmask)
                                        | (dat_i & wmask);
            end
            if (idx == soic_pkg::IDX_USER) begin
                user_access_value_o <= (user_access_value_o & ~wmask)
                                       | (dat_i & wmask);
            end
        end
    end

    // Multi-frame write hands each word to the compression path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multi_frame_write_o <= 32'h0000_0000;
            multi_frame_write_valid_o <= 1'b0;
        end else begin
            multi_frame_write_valid_o <= wr_fire
                                         && idx == soic_pkg::IDX_MFW;
            if (wr_fire && idx == soic_pkg::IDX_MFW) begin
                multi_frame_write_o <= dat_i & wmask;
            end
        end
    end

    // Identity match latch; a mismatching write revokes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_ok <= 1'b0;
        end else if (wr_fire && idx == soic_pkg::IDX_IDENT) begin
            id_ok <= (dat_i & wmask) == IDENTITY;
        end
    end

    // Frame data passes only behind a good identity check
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_data_o <= 32'h0000_0000;
            frame_data_valid_o <= 1'b0;
        end else begin
            frame_data_valid_o <= wr_fire && id_ok
                                  && idx == soic_pkg::IDX_FRAME_DATA;
            if (wr_fire && id_ok && idx == soic_pkg::IDX_FRAME_DATA) begin
                frame_data_o <= dat_i & wmask;
            end
        end
    end

    // Error flag: a bad frame write sets it, a good identity clears it,
    // and the set wins when both land together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_error <= 1'b0;
        end else if (wr_fire && !id_ok
                     && idx == soic_pkg::IDX_FRAME_DATA) begin
            id_error <= 1'b1;
        end else if (wr_fire && idx == soic_pkg::IDX_IDENT
                     && (dat_i & wmask) == IDENTITY) begin
            id_error <= 1'b0;
        end
    end

    // Control register: start is a self-clearing strobe
    assign start_pulse = wr_fire && idx == soic_pkg::IDX_CONTROL
                         && sel_i[0] && dat_i[soic_pkg::CTRL_START_BIT];

    soic_rate_div #(
        .UNIT(DIV_STEP)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ext_sel_i(startup_options[soic_pkg::OPT_EXT_CLK_BIT]),
        .ext_clk_i(external_master_cfg_clock_i),
        .rate_sel_i(startup_options[soic_pkg::OPT_RATE_LSB +:
                                    soic_pkg::RATE_W]),
        .tick_o(cfg_tick),
        .cfg_clock_o(cfg_clock_o)
    );

    soic_phase_seq u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_pulse),
        .tick_i(cfg_tick),
        .done_code_i(startup_options[soic_pkg::OPT_DONE_LSB +: 3]),
        .match_code_i(startup_options[soic_pkg::OPT_MATCH_LSB +: 3]),
        .lock_code_i(startup_options[soic_pkg::OPT_LOCK_LSB +: 3]),
        .gts_code_i(startup_options[soic_pkg::OPT_GTS_LSB +: 3]),
        .gwe_code_i(startup_options[soic_pkg::OPT_GWE_LSB +: 3]),
        .match_ok_i(impedance_calibration_match_i),
        .lock_ok_i(clock_manager_locked_i),
        .phase_o(phase),
        .phase_gray_o(phase_gray),
        .done_rel_o(done_rel),
        .gts_rel_o(gts_rel),
        .gwe_rel_o(gwe_rel),
        .end_o(seq_end)
    );

    // Completion pin: open drain pulls low until release; driven style
    // also drives high once released, risking contention on shared lines
    assign done_oe_o = startup_options[soic_pkg::OPT_DRIVE_DONE_BIT]
                       || !done_rel;
    assign done_o = startup_options[soic_pkg::OPT_DRIVE_DONE_BIT]
                    && done_rel;
    assign global_tristate_o = !gts_rel;
    assign global_write_enable_o = gwe_rel;

    // Event edges for the interrupt status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            end_prev <= 1'b0;
        end else begin
            end_prev <= seq_end;
        end
    end
    assign irq_event[soic_pkg::IRQ_IDERR] = wr_fire && !id_ok
                                            && idx == soic_pkg::IDX_FRAME_DATA;
    assign irq_event[soic_pkg::IRQ_EOS] = seq_end && !end_prev;

    // Sticky status with write-one-to-clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            irq_status <= (irq_status
                           & ~((wr_fire && idx == soic_pkg::IDX_IRQ_CLEAR)
                               ? dat_i[soic_pkg::IRQ_W-1:0] & {2{sel_i[0]}}
                               : '0))
                          | irq_event;
            if (wr_fire && idx == soic_pkg::IDX_IRQ_ENABLE && sel_i[0]) begin
                irq_enable <= dat_i[soic_pkg::IRQ_W-1:0];
            end
        end
    end
    assign irq_o = |(irq_status & irq_enable);

    // Configuration status word
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[soic_pkg::STAT_PHASE_LSB +: 3] = phase_gray;
        status_word[soic_pkg::STAT_IDERR_BIT] = id_error;
        status_word[soic_pkg::STAT_DONE_PIN_BIT] = done_pin_i;
        status_word[soic_pkg::STAT_DONE_BIT] = done_rel;
        status_word[soic_pkg::STAT_GWE_BIT] = gwe_rel;
        status_word[soic_pkg::STAT_GTS_BIT] = gts_rel;
        status_word[soic_pkg::STAT_EOS_BIT] = seq_end;
        status_word[soic_pkg::STAT_MATCH_BIT] = impedance_calibration_match_i;
        status_word[soic_pkg::STAT_LOCK_BIT] = clock_manager_locked_i;
    end

    // Read mux; write-only words and holes read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (idx)
            soic_pkg::IDX_STATUS: next_rdata = status_word;
            soic_pkg::IDX_OPTIONS: next_rdata = startup_options;
            soic_pkg::IDX_IDENT: next_rdata = IDENTITY;
            soic_pkg::IDX_USER: next_rdata = user_access_value_o;
            soic_pkg::IDX_IRQ_STATUS: next_rdata = 32'(irq_status);
            soic_pkg::IDX_IRQ_ENABLE: next_rdata = 32'(irq_enable);
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_o <= next_rdata;
        end
    end

    // Checks
    sequence s_bad_frame;
        wr_fire && !id_ok && idx == soic_pkg::IDX_FRAME_DATA;
    endsequence
    sequence s_err_seen;
        id_error && irq_status[soic_pkg::IRQ_IDERR];
    endsequence

    a_chain_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        !daisy_chain_active_i |-> !serial_chain_o)
        else $error("serial chain driven outside chaining");
    a_done_style: assert property (@(posedge clk_i) disable iff (rst_i)
        !startup_options[24] && done_oe_o |-> !done_o)
        else $error("open drain completion pin driven high");
    a_done_open: assert property (@(posedge clk_i) disable iff (rst_i)
        !startup_options[24] && done_rel |-> !done_oe_o)
        else $error("completion pin held after release");
    a_gts_track: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(startup_options) && startup_options[5:3] == 3'h6
        |-> global_tristate_o == !done_rel)
        else $error("tristate does not follow completion");
    a_gwe_track: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(startup_options) && startup_options[2:0] == 3'h6
        |-> global_write_enable_o == done_rel)
        else $error("write enable does not follow completion");
    a_mfw_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && idx == 6'h0A |=> multi_frame_write_valid_o ##1
        !multi_frame_write_valid_o)
        else $error("multi-frame write pulse wrong");
    a_iv_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && idx == 6'h0B && sel_i == 4'hF
        |=> cipher_init_vector_o == $past(dat_i))
        else $error("cipher vector not stored");
    a_frame_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_data_valid_o |-> $past(id_ok))
        else $error("frame data passed without identity");
    a_ident_read: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && idx == 6'h0C |=> ack_o && dat_o == IDENTITY)
        else $error("identity read wrong");
    a_user_value: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && idx == 6'h0D && sel_i == 4'hF
        |=> user_access_value_o == $past(dat_i))
        else $error("user access value not stored");
    a_id_error: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bad_frame |=> s_err_seen)
        else $error("identity error not flagged");
    a_phase_report: assert property (@(posedge clk_i) disable iff (rst_i)
        phase == 3'h4 |-> status_word[20:18] == 3'h6)
        else $error("phase status code wrong");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (startup_options & ~32'h057E_7FFF) == 32'h0000_0000)
        else $error("reserved option bits stored");
endmodule : soic_regs
`default_nettype wire

// ==== testbench/soic_cfg_source.sv ====
// Model of the configuration source: a classic Wishbone master.
// Assumes one clock; the bench calls xfer through the hierarchy.
`timescale 1ns/100ps
`default_nettype none
module soic_cfg_source (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // One whole-word cycle; held until ack, so no wait count is assumed
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'h0;
    endtask : xfer
endmodule : soic_cfg_source
`default_nettype wire

// ==== testbench/startup_options_and_id_check_bench.sv ====
// Self-checking bench for the start-up options and identity check block.
// Assumes the source model drives the register bus; pins held quiet except the chain and external clock inputs.
`timescale 1ns/100ps
`default_nettype none
module startup_options_and_id_check_bench;
    localparam logic [31:0] IDENT = 32'h0A5C_3001; // Arbitrary value
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, irq, fvalid;
    logic chain = 1'b0;
    logic ext = 1'b0;
    wire [4:0] pin;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, fdat, civ, uav, mfw;
    int failures = 0;
    int tests_run = 0;
    int frames = 0;
    int cycles = 0;
    always #5 clk_i = ~clk_i;
    // Count frame pulses; a hung bus wait ends in the timeout
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (fvalid === 1'b1) frames <= frames + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    soic_cfg_source u_soic_cfg_source (.clk_i(clk_i), .ack_i(ack),
        .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat));
    soic_regs #(.IDENTITY(IDENT)) u_soic_regs (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .daisy_chain_active_i(chain), .serial_chain_o(pin[4]),
        .external_master_cfg_clock_i(ext), .cfg_clock_o(),
        .impedance_calibration_match_i(1'b1),
        .clock_manager_locked_i(1'b1), .done_pin_i(1'b0), .done_o(pin[2]),
        .done_oe_o(pin[3]), .global_tristate_o(pin[1]),
        .global_write_enable_o(pin[0]),
        .frame_data_o(fdat), .frame_data_valid_o(fvalid),
        .multi_frame_write_o(mfw), .multi_frame_write_valid_o(),
        .cipher_init_vector_o(civ), .user_access_value_o(uav),
        .irq_o(irq));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_soic_cfg_source.xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        u_soic_cfg_source.xfer(1'b0, a, 32'h0, d);
    endtask : rd
    task automatic test_options;
        rd(8'h24, q);
        check("options reset", q, soic_pkg::OPT_RESET);
        wr(8'h24, 32'hFA87_AFF0);
        rd(8'h24, q);
        check("options mask", q, 32'h0006_2FF0);
        rd(8'hFC, q);
        check("unmapped read", q, 32'h0);
        $display("options test done");
    endtask : test_options
    task automatic test_data_regs;
        wr(8'h2C, 32'h1234_ABCD);
        wr(8'h34, 32'h5A5A_0F0F);
        wr(8'h28, 32'h0F1E_2D3C);
        @(posedge clk_i);
        check("cipher vector", civ, 32'h1234_ABCD);
        check("user value", uav, 32'h5A5A_0F0F);
        check("multi frame", mfw, 32'h0F1E_2D3C);
        $display("data register test done");
    endtask : test_data_regs
    task automatic test_identity;
        rd(8'h30, q);
        check("identity read", q, IDENT);
        wr(8'h44, 32'h1);
        wr(8'h08, 32'h1234_5678); // Frame data before identity, on purpose
        repeat (2) @(posedge clk_i);
        rd(8'h1C, q);
        check("id error flag", q & 32'h8000, 32'h8000);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(8'h48, 32'h1);
        wr(8'h30, ~IDENT);
        wr(8'h08, 32'h1111_2222);
        repeat (2) @(posedge clk_i);
        check("refused frames", 32'(frames), 32'h0);
        wr(8'h30, IDENT);
        wr(8'h48, 32'h1);
        wr(8'h08, 32'hCAFE_0001);
        repeat (2) @(posedge clk_i);
        check("irq cleared", {31'h0, irq}, 32'h0);
        check("accepted frames", 32'(frames), 32'h1);
        check("frame data", fdat, 32'hCAFE_0001);
        $display("identity test done");
    endtask : test_identity
    task automatic test_startup;
        check("pins idle", 32'(pin), 32'hA);
        wr(8'h4C, 32'h1);
        repeat (100) @(posedge clk_i);
        check("pins released", 32'(pin), 32'h1);
        rd(8'h1C, q);
        check("status", q, 32'h0010_207C);
        wr(8'h24, 32'h0106_2FF0);
        @(posedge clk_i);
        check("done driven", 32'(pin), 32'hD);
        $display("startup test done");
    endtask : test_startup
    task automatic test_chain;
        wr(8'h20, 32'hFFFF_FFFF);
        check("chain idle", 32'(pin), 32'hD);
        chain <= 1'b1;
        repeat (200) @(posedge clk_i);
        check("chain early", 32'(pin), 32'h1D);
        repeat (100) @(posedge clk_i);
        check("chain shifted", 32'(pin), 32'hD);
        wr(8'h24, 32'h0506_2FF0);
        wr(8'h20, 32'hFFFF_FFFF);
        repeat (20) @(posedge clk_i);
        check("no ext edge", 32'(pin), 32'h1D);
        repeat (64) @(posedge clk_i) ext <= ~ext;
        repeat (4) @(posedge clk_i);
        check("ext shifted", 32'(pin), 32'hD);
        chain <= 1'b0;
        $display("chain test done");
    endtask : test_chain
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        test_options();
        test_data_regs();
        test_identity();
        test_startup();
        test_chain();
        final_report();
    end
endmodule : startup_options_and_id_check_bench
`default_nettype wire
